// ===== pfc_pkg.sv
// Package for the parallel flash host controller: register map, codes and timing
package pfc_pkg;
   // ======================================================================
   // Register map (byte addresses, Avalon-MM word aligned)
   localparam logic [3:0] REG_CTRL   = 4'h0;   // Write: start command; read: busy/done
   localparam logic [3:0] REG_ADDR   = 4'h4;   // Target flash address
   localparam logic [3:0] REG_WDATA  = 4'h8;   // Data byte for program
   localparam logic [3:0] REG_RDATA  = 4'hc;   // Last byte read / poll result
   localparam logic [31:0] REG_CTRL_RST = 32'h0;

   // ======================================================================
   // Command codes written by software into REG_CTRL[3:0]
   typedef enum logic [3:0]
   {
      PFC_OP_READ    = 4'h0,
      PFC_OP_PROG    = 4'h1,
      PFC_OP_SECT    = 4'h2,
      PFC_OP_CHIP    = 4'h3,
      PFC_OP_PROT_B  = 4'h4,
      PFC_OP_PROT_T  = 4'h5,
      PFC_OP_STATUS  = 4'h6,
      PFC_OP_ID      = 4'h7,
      PFC_OP_EXIT    = 4'h8
   } pfc_op_e;

   // ======================================================================
   // Bus codes and unlock addresses
   localparam logic [7:0]  CD_AA = 8'haa;
   localparam logic [7:0]  CD_55 = 8'h55;
   localparam logic [7:0]  CD_PROG = 8'ha0;
   localparam logic [7:0]  CD_ERASE = 8'h80;
   localparam logic [7:0]  CD_SECT = 8'h30;
   localparam logic [7:0]  CD_CHIP = 8'h10;
   localparam logic [7:0]  CD_PROT = 8'h70;
   localparam logic [7:0]  CD_STAT = 8'h95;
   localparam logic [7:0]  CD_ID = 8'h90;
   localparam logic [7:0]  CD_EXIT = 8'hf0;
   localparam logic [18:0] AD_5555 = 19'h05555;
   localparam logic [18:0] AD_2AAA = 19'h02aaa;
   localparam int          POLL_BIT = 7;
   localparam int          ALT_BIT = 6;

   // ======================================================================
   // Timing: each bus phase lasts one 100 ns cycle, well above 5 ns pulse floor
   localparam int CLK_NS        = 100;
   localparam int STROBE_MIN_NS = 5;
   localparam int STROBE_CYC    = (STROBE_MIN_NS + CLK_NS - 1) / CLK_NS;
   localparam int READ_CYC_NS   = 100;
   localparam int READ_CYC      = (READ_CYC_NS + CLK_NS - 1) / CLK_NS;
endpackage : pfc_pkg

// ===== pfc_host.sv
// Host controller that drives a parallel flash through its command pins
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// Notes on behaviour
// - Protect uses six writes ending 70h; 2aaa top, 5555 bottom.
// - Status: aa/5555, 55/2aaa, 95/5555, read; bits 1..0 tell block.
// - Program needs three-write prefix, erase six writes, always.
// - Program: aa/5555, 55/2aaa, a0/5555, then data at target.
// - Erase: five-write prefix then 30h at sector or 10h at 5555.
// - After 90h entry, address bit 0 picks maker or part code.
module pfc_host
   import pfc_pkg::*;
#(
   parameter int AW = 19
)
(
   input  wire logic          clk,
   input  wire logic          sys_rst,
   input  wire logic [3:0]    avs_address,
   input  wire logic          avs_read,
   input  wire logic          avs_write,
   input  wire logic [31:0]   avs_writedata,
   output logic [31:0]        avs_readdata,
   output logic               avs_waitrequest,
   output logic [AW-1:0]      fl_addr,
   output logic               fl_ce_n,
   output logic               fl_oe_n,
   output logic               fl_we_n,
   input  wire logic [7:0]    fl_dq_in,
   output logic [7:0]         fl_dq_out,
   output logic               fl_dq_oe
);
   import pfc_pkg::*;

   typedef enum {ST_IDLE, ST_WSET, ST_WLOW, ST_WHI, ST_RSET, ST_RLOW, ST_DONE} pfc_st_e;

   // ======================================================================
   // Sequence step table
   function automatic logic [AW+7:0] step_of(input pfc_op_e op, input logic [2:0] i,
                                           input logic [AW-1:0] a, input logic [7:0] d);
      logic [AW-1:0] ad;
      logic [7:0]    cd;
      ad = AW'(AD_5555);
      cd = CD_AA;
      unique case (i)
         3'd0: begin ad = AW'(AD_5555); cd = (op == PFC_OP_EXIT) ? CD_EXIT : CD_AA; end
         3'd1, 3'd4: begin ad = AW'(AD_2AAA); cd = CD_55; end
         3'd2: begin
            ad = AW'(AD_5555);
            unique case (op)
               PFC_OP_PROG:   cd = CD_PROG;
               PFC_OP_STATUS: cd = CD_STAT;
               PFC_OP_ID:     cd = CD_ID;
               default:       cd = CD_ERASE;
            endcase
         end
         3'd3: begin
            ad = (op == PFC_OP_PROG) ? a : AW'(AD_5555);
            cd = (op == PFC_OP_PROG) ? d : CD_AA;
         end
         default: begin
            unique case (op)
               PFC_OP_SECT:   begin ad = a; cd = CD_SECT; end
               PFC_OP_CHIP:   begin ad = AW'(AD_5555); cd = CD_CHIP; end
               PFC_OP_PROT_T: begin ad = AW'(AD_2AAA); cd = CD_PROT; end
               default:       begin ad = AW'(AD_5555); cd = CD_PROT; end
            endcase
         end
      endcase
      return {ad, cd};
   endfunction : step_of

   // Number of writes each order needs
   function automatic logic [2:0] nwr(input pfc_op_e op);
      unique case (op)
         PFC_OP_READ:                        nwr = 3'd0;
         PFC_OP_EXIT:                        nwr = 3'd1;
         PFC_OP_STATUS, PFC_OP_ID:           nwr = 3'd3;
         PFC_OP_PROG:                        nwr = 3'd4;
         default:                            nwr = 3'd6;
      endcase
   endfunction : nwr

   pfc_st_e       st_ff, nxt_st;
   pfc_op_e       op_ff, nxt_op;
   logic [2:0]    idx_ff, nxt_idx;
   logic [AW-1:0] addr_ff, nxt_addr;
   logic [7:0]    wd_ff, nxt_wd;
   logic [7:0]    rd_ff, nxt_rd;
   logic [7:0]    prev_ff, nxt_prev;
   logic          poll_ff, nxt_poll;
   logic          pv_ff, nxt_pv;
   logic          done_ff, nxt_done;
   logic [AW+7:0] stp;
   logic          busy;

   assign busy = (st_ff != ST_IDLE);
   assign stp  = step_of(op_ff, idx_ff, addr_ff, wd_ff);

   // ======================================================================
   // Sequencer: all strobes held one full cycle, so no pulse is under 5 ns
   always_comb
   begin
      nxt_st = st_ff; nxt_op = op_ff; nxt_idx = idx_ff; nxt_addr = addr_ff;
      nxt_wd = wd_ff; nxt_rd = rd_ff; nxt_prev = prev_ff; nxt_poll = poll_ff;
      nxt_pv = pv_ff; nxt_done = done_ff;
      unique case (st_ff)
         ST_IDLE:
         begin
            if (avs_write && avs_address == REG_ADDR) nxt_addr = avs_writedata[AW-1:0];
            if (avs_write && avs_address == REG_WDATA) nxt_wd = avs_writedata[7:0];
            // Codes past exit are dropped: the step table would run them as protect
            if (avs_write && avs_address == REG_CTRL && avs_writedata[3:0] <= PFC_OP_EXIT)
            begin
               nxt_op   = pfc_op_e'(avs_writedata[3:0]);
               nxt_idx  = 3'd0;
               nxt_done = 1'b0;
               nxt_pv   = 1'b0;
               nxt_poll = 1'b0;
               nxt_st   = (nwr(pfc_op_e'(avs_writedata[3:0])) == 3'd0) ? ST_RSET : ST_WSET;
            end
         end
         ST_WSET: nxt_st = ST_WLOW;               // Address set up before strobe
         ST_WLOW: nxt_st = ST_WHI;                // strobe wide; data latched at rise
         ST_WHI:
         begin
            nxt_idx = idx_ff + 3'd1;
            if (idx_ff + 3'd1 == nwr(op_ff))      // full sequence issued
            begin
               // Program, erase, protect: poll after last pulse rises
               nxt_poll = (op_ff != PFC_OP_STATUS) && (op_ff != PFC_OP_ID)
                          && (op_ff != PFC_OP_EXIT);
               nxt_st   = nxt_poll ? ST_RSET : ST_DONE;
            end
            else
               nxt_st = ST_WSET;
         end
         ST_RSET: nxt_st = ST_RLOW;
         ST_RLOW:
         begin
            nxt_rd   = fl_dq_in;
            nxt_prev = fl_dq_in;
            nxt_pv   = 1'b1;
            // done when bit 6 stops alternating between two reads
            if (!poll_ff || (pv_ff && prev_ff[ALT_BIT] == fl_dq_in[ALT_BIT]))
               nxt_st = ST_DONE;
            else
               nxt_st = ST_RSET;
         end
         ST_DONE:
         begin
            nxt_done = 1'b1;
            nxt_st   = ST_IDLE;
         end
      endcase
   end

   // Sequencer registers
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         st_ff <= ST_IDLE; op_ff <= PFC_OP_READ; idx_ff <= 3'd0;
         addr_ff <= '0; wd_ff <= 8'h00; rd_ff <= 8'h00; prev_ff <= 8'h00;
         poll_ff <= 1'b0; pv_ff <= 1'b0; done_ff <= 1'b0;
      end
      else
      begin
         st_ff <= nxt_st; op_ff <= nxt_op; idx_ff <= nxt_idx;
         addr_ff <= nxt_addr; wd_ff <= nxt_wd; rd_ff <= nxt_rd; prev_ff <= nxt_prev;
         poll_ff <= nxt_poll; pv_ff <= nxt_pv; done_ff <= nxt_done;
      end
   end

   // ======================================================================
   // Pin drive: output gate held high across writes so none is inhibited
   always_comb
   begin
      fl_addr   = (st_ff == ST_WSET || st_ff == ST_WLOW || st_ff == ST_WHI)
                  ? stp[AW+7:8] : addr_ff;
      fl_dq_out = stp[7:0];
      fl_dq_oe  = (st_ff == ST_WSET || st_ff == ST_WLOW || st_ff == ST_WHI);
      fl_ce_n   = !(fl_dq_oe || st_ff == ST_RLOW);
      fl_we_n   = (st_ff != ST_WLOW);
      fl_oe_n   = (st_ff != ST_RLOW);
   end

   // Avalon slave: control writes stall while busy, reads answer at once
   always_comb
   begin
      avs_waitrequest = busy && avs_write && (avs_address == REG_CTRL);
      avs_readdata    = 32'h0;
      // Data shown only while a read is asked for
      if (avs_read)
      begin
         unique case (avs_address)
            REG_CTRL:  avs_readdata = {30'h0, done_ff, busy};
            REG_ADDR:  avs_readdata = 32'(addr_ff);
            REG_WDATA: avs_readdata = {24'h0, wd_ff};
            REG_RDATA: avs_readdata = {24'h0, rd_ff};
            default:   avs_readdata = 32'h0;
         endcase
      end
   end

   // ======================================================================
   // Checks
   a_we_oe_excl: assert property (@(posedge clk) disable iff (sys_rst)
      !(!fl_we_n && !fl_oe_n)) else $error("strobe and output gate both low");
   a_we_with_ce: assert property (@(posedge clk) disable iff (sys_rst)
      !fl_we_n |-> !fl_ce_n) else $error("strobe without select");
   a_we_width: assert property (@(posedge clk) disable iff (sys_rst)
      $fell(fl_we_n) |=> fl_we_n) else $error("strobe width wrong");
   a_prog_len: assert property (@(posedge clk) disable iff (sys_rst)
      (st_ff == ST_WHI && op_ff == PFC_OP_PROG && idx_ff == 3'd3) |=> st_ff == ST_RSET)
      else $error("program not polled after fourth pulse");
   a_erase_len: assert property (@(posedge clk) disable iff (sys_rst)
      (st_ff == ST_WHI && op_ff == PFC_OP_SECT) |-> idx_ff <= 3'd5)
      else $error("erase too long");
   a_prot_code: assert property (@(posedge clk) disable iff (sys_rst)
      (!fl_we_n && op_ff == PFC_OP_PROT_T && idx_ff == 3'd5) |->
      (fl_dq_out == CD_PROT && fl_addr == AW'(AD_2AAA))) else $error("bad protect");
   a_unlock_first: assert property (@(posedge clk) disable iff (sys_rst)
      (!fl_we_n && idx_ff == 3'd0 && op_ff != PFC_OP_EXIT) |-> fl_dq_out == CD_AA)
      else $error("missing unlock");
   a_stat_code: assert property (@(posedge clk) disable iff (sys_rst)
      (!fl_we_n && op_ff == PFC_OP_STATUS && idx_ff == 3'd2) |-> fl_dq_out == CD_STAT)
      else $error("bad status entry");
   a_dq_drive: assert property (@(posedge clk) disable iff (sys_rst)
      !fl_we_n |-> fl_dq_oe) else $error("strobe without data driven");
   a_dq_no_fight: assert property (@(posedge clk) disable iff (sys_rst)
      !(fl_dq_oe && !fl_oe_n)) else $error("host drives bus during read");
   c_prog: cover property (@(posedge clk) op_ff == PFC_OP_PROG && st_ff == ST_DONE);
   c_sect: cover property (@(posedge clk) op_ff == PFC_OP_SECT && st_ff == ST_DONE);
   c_prot: cover property (@(posedge clk) op_ff == PFC_OP_PROT_B && st_ff == ST_DONE);
endmodule : pfc_host
`default_nettype wire

// ===== pfc_flash_model.sv
// Behavioural parallel flash that answers the host controller on its pins
`timescale 1ns/10ps
`default_nettype none
// ====================
// Flash model
module pfc_flash_model
   import pfc_pkg::*;
#(
   parameter int         AW      = 19,
   parameter int         BUSY_RD = 3,
   parameter logic [7:0] MAKER   = 8'h5a,  // Arbitrary value
   parameter logic [7:0] PART    = 8'h3c   // Arbitrary value
)
(
   input  wire logic [AW-1:0] fl_addr,
   input  wire logic          fl_ce_n,
   input  wire logic          fl_oe_n,
   input  wire logic          fl_we_n,
   input  wire logic [7:0]    fl_dq_out,
   input  wire logic          fl_dq_oe,
   output logic [7:0]         fl_dq_in
);
   logic [7:0] mem [0:(1<<AW)-1];
   logic [7:0] last = 8'h00;
   logic [2:0] step = 3'h0;
   logic [1:0] prot = 2'h0;
   logic [1:0] mode = 2'h0;
   logic [1:0] kind = 2'h0;
   logic       tgl  = 1'b0;
   int         busy = 0;
   realtime    t_low = 0;
   wire        rd_n = fl_ce_n | fl_oe_n;

   function automatic logic blk(input logic [AW-1:0] a);
      return (prot[0] && a < 'h4000) || (prot[1] && a >= (1 << AW) - 'h4000);
   endfunction : blk

   // Busy length counts reads, so slow answers come without long runs
   task automatic go(input logic [1:0] k);
      kind = k;
      busy = (k == 2'h0) ? BUSY_RD : 2 * BUSY_RD;
   endtask : go

   task automatic wr(input logic [AW-1:0] a, input logic [7:0] d);
      logic c5;
      logic c2;
      c5 = a[14:0] == 15'h5555;
      c2 = a[14:0] == 15'h2aaa;
      if (busy > 0)
         return;
      if (step == 3'h0 && d == CD_EXIT)
         mode = 2'h0;
      case (step)
         3'h0: step = (c5 && d == CD_AA) ? 3'h1 : 3'h0;
         3'h1, 3'h5: step = (c2 && d == CD_55) ? step + 3'h1 : 3'h0;
         3'h4: step = (c5 && d == CD_AA) ? 3'h5 : 3'h0;
         3'h2:
         begin
            step = !c5 ? 3'h0 : (d == CD_PROG) ? 3'h3 : (d == CD_ERASE) ? 3'h4 : 3'h0;
            if (c5 && d == CD_STAT) mode = 2'h1;
            if (c5 && d == CD_ID) mode = 2'h2;
            if (c5 && d == CD_EXIT) mode = 2'h0;
         end
         3'h3:
         begin
            step = 3'h0;
            if (!blk(a)) begin mem[a] = d; go(2'h0); end
         end
         default:
         begin
            step = 3'h0;
            if (d == CD_SECT && !blk(a))
            begin
               for (int i = 0; i < 4096; i++) mem[{a[AW-1:12], 12'h0} + i] = 8'hff;
               go(2'h1);
            end
            if (d == CD_CHIP && c5)
            begin
               foreach (mem[i]) if (!blk(AW'(i))) mem[i] = 8'hff;
               go(2'h1);
            end
            if (d == CD_PROT && prot == 2'h0)
            begin
               prot = c2 ? 2'b10 : 2'b01;
               go(2'h2);
            end
         end
      endcase
   endtask : wr

   initial foreach (mem[i]) mem[i] = 8'hff;
   always @(negedge fl_we_n) t_low = $realtime;

   // A write lands at the strobe rise; short or inhibited pulses do nothing
   always @(posedge fl_we_n)
   begin
      if (!fl_ce_n && fl_oe_n && fl_dq_oe && $realtime - t_low >= 5.0)
         wr(fl_addr, fl_dq_out);
   end

   // Each read starts when select and output gate are both low
   always @(negedge rd_n)
   begin
      if (busy > 0)
      begin
         tgl = ~tgl;
         busy--;
         last = {kind == 2'h1 ? 1'b0 : ~mem[fl_addr][7], tgl, mem[fl_addr][5:0]};
      end
      else if (mode == 2'h1) last = {6'h0, prot};
      else if (mode == 2'h2) last = fl_addr[0] ? PART : MAKER;
      else last = mem[fl_addr];
   end
   // Released bus shows no stale byte
   assign fl_dq_in = rd_n ? ~last : last;
endmodule : pfc_flash_model
`default_nettype wire

// ===== pfc_host_test.sv
// Self-checking bench for the parallel flash host controller
`timescale 1ns/10ps
`default_nettype none
// ====================
// Bench top
module pfc_host_test;
   import pfc_pkg::*;
   localparam logic [7:0] MAKER = 8'h5a;  // Arbitrary value
   localparam logic [7:0] PART  = 8'h3c;  // Arbitrary value
   logic        clk = 0, sys_rst = 1, avs_read = 0, avs_write = 0;
   logic [3:0]  avs_address = 0;
   logic [31:0] avs_writedata = 0, avs_readdata, rd;
   logic        avs_waitrequest, fl_ce_n, fl_oe_n, fl_we_n, fl_dq_oe;
   logic [18:0] fl_addr, pa [4];
   logic [7:0]  fl_dq_in, fl_dq_out, pd [4];
   int          err_total = 0, comparisons = 0, cyc = 0, seed = 64;

   always #50 clk = ~clk;

   pfc_host #(.AW(19)) pfc_host_inst (.clk(clk), .sys_rst(sys_rst),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .fl_addr(fl_addr), .fl_ce_n(fl_ce_n),
      .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n), .fl_dq_in(fl_dq_in),
      .fl_dq_out(fl_dq_out), .fl_dq_oe(fl_dq_oe));
   pfc_flash_model #(.AW(19), .MAKER(MAKER), .PART(PART)) pfc_flash_model_inst (
      .fl_addr(fl_addr), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n),
      .fl_dq_out(fl_dq_out), .fl_dq_oe(fl_dq_oe), .fl_dq_in(fl_dq_in));

   task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         err_total++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   // One Avalon transfer, held until waitrequest is seen low
   task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= wr;
      avs_read      <= !wr;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
   endtask : bus

   // Issue an operation and poll busy under a bounded count
   task op(input pfc_op_e o, input logic [18:0] a, input logic [7:0] d);
      bus(1'b1, REG_ADDR, {13'h0, a});
      bus(1'b1, REG_WDATA, {24'h0, d});
      bus(1'b1, REG_CTRL, {28'h0, o});
      for (int i = 0; i < 3000 && (i == 0 || rd[0] !== 1'b0); i++) bus(1'b0, REG_CTRL, 0);
      check("ctrl done", rd[1:0], 2'b10);
   endtask : op

   task rdb(input logic [18:0] a, input logic [7:0] e);
      op(PFC_OP_READ, a, 8'h00);
      bus(1'b0, REG_RDATA, 0);
      check("rdata", rd, {24'h0, e});
   endtask : rdb

   // A sector erase of the first address clears any byte sharing its sector
   function automatic logic [7:0] after_erase(input int k);
      return (pa[k][18:12] == pa[0][18:12]) ? 8'hff : pd[k];
   endfunction : after_erase

   task finish_test;
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : finish_test

   // Hang guard well above the expected run length
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin err_total++; finish_test; end
   end

   initial
   begin
      repeat (16) @(posedge clk);
      sys_rst <= 1'b0;
      bus(1'b0, REG_CTRL, 0);
      check("ctrl reset", rd, REG_CTRL_RST);
      bus(1'b0, 4'h2, 0);
      check("unmapped", rd, 0);
      bus(1'b1, REG_CTRL, 32'hf);
      bus(1'b0, REG_CTRL, 0);
      check("bad code", rd, 0);
      for (int i = 0; i < 4; i++)
      begin
         pa[i] = 19'h04000 + 19'($unsigned($random(seed)) % 32'h78000);
         pd[i] = 8'($random(seed));
         op(PFC_OP_PROG, pa[i], pd[i]);
      end
      for (int i = 0; i < 4; i++) rdb(pa[i], pd[i]);
      op(PFC_OP_SECT, pa[0], 8'h00);
      for (int i = 0; i < 4; i++) rdb(pa[i], after_erase(i));
      $display("test program and erase done");
      op(PFC_OP_STATUS, 0, 8'h00);
      rdb(19'h12345, 8'h00);
      op(PFC_OP_EXIT, 0, 8'h00);
      op(PFC_OP_PROG, 19'h03fff, 8'h3c);
      op(PFC_OP_PROT_B, 0, 8'h00);
      op(PFC_OP_PROT_T, 0, 8'h00);
      op(PFC_OP_STATUS, 0, 8'h00);
      rdb(19'h7ffff, 8'h01);
      op(PFC_OP_EXIT, 0, 8'h00);
      op(PFC_OP_PROG, 19'h03fff, 8'h00);
      rdb(19'h03fff, 8'h3c);
      op(PFC_OP_SECT, 19'h03000, 8'h00);
      rdb(19'h03fff, 8'h3c);
      op(PFC_OP_PROG, 19'h04000, 8'h00);
      rdb(19'h04000, 8'h00);
      op(PFC_OP_CHIP, 0, 8'h00);
      rdb(19'h04000, 8'hff);
      rdb(19'h03fff, 8'h3c);
      $display("test protection done");
      op(PFC_OP_ID, 0, 8'h00);
      rdb(19'h00000, MAKER);
      rdb(19'h00001, PART);
      op(PFC_OP_EXIT, 0, 8'h00);
      rdb(19'h00001, 8'hff);
      $display("test identification done");
      finish_test;
   end
endmodule : pfc_host_test
`default_nettype wire
